// *** design/wnio_pkg.sv ***
// Constants for the wireless node digital I/O supervision block.
// Assumes a 10 MHz system clock; all config arrives as plain ports.
package wnio_pkg;

  // ==========================================================================
  // Timebase
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned TICK_PERIOD_S   = 1;
  localparam int unsigned TICK_CYCLES     = CLK_HZ * TICK_PERIOD_S;

  // ==========================================================================
  // Field widths and ranges
  localparam int unsigned NUM_DI          = 4;
  localparam int unsigned NUM_AI          = 4;
  localparam int unsigned VAL_W           = 16;
  localparam int unsigned PERIOD_W        = 16;
  localparam int unsigned WARM_W          = 8;
  localparam int unsigned CYC_W           = 4;
  localparam int unsigned SLOT_W          = 6;
  localparam logic [CYC_W-1:0]  CYC_MIN   = 4'h1;
  localparam logic [CYC_W-1:0]  CYC_MAX   = 4'hA;
  localparam logic [SLOT_W-1:0] SLOT_MIN  = 6'h01;
  localparam logic [SLOT_W-1:0] SLOT_MAX  = 6'h37;
  localparam logic [VAL_W-1:0]  SENTINEL  = 16'hFFFF;

  // ==========================================================================
  // Encodings
  typedef enum logic [1:0] {
    WN_TRIG_OFF  = 2'b00,
    WN_TRIG_RISE = 2'b01,
    WN_TRIG_FALL = 2'b10,
    WN_TRIG_BOTH = 2'b11
  } wn_trig_t;

  typedef enum logic [1:0] {
    WN_START_OFF  = 2'b00,
    WN_START_ON   = 2'b01,
    WN_START_LAST = 2'b10
  } wn_start_t;

  typedef enum logic [1:0] {
    WN_LOSS_OFF  = 2'b00,
    WN_LOSS_ON   = 2'b01,
    WN_LOSS_HOLD = 2'b10
  } wn_loss_t;

  typedef enum logic [1:0] {
    WN_AI_OFF     = 2'b00,
    WN_AI_CURRENT = 2'b01,
    WN_AI_VOLTAGE = 2'b10
  } wn_ai_t;

  typedef enum logic [1:0] {
    WN_ST_SLEEP = 2'b00,
    WN_ST_WARM  = 2'b01,
    WN_ST_SEND  = 2'b10
  } wn_state_t;

endpackage : wnio_pkg

// *** design/wnio_tick.sv ***
// One-cycle enable pulse once per second from the system clock.
// Assumes a single free-running clock; no other timebase exists.
`timescale 1ns/10ps
module wnio_tick #(
  parameter int unsigned DIV = 10_000_000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Slow enable
  output logic      tick
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic        next_tick;

  always_comb begin
    next_tick = 1'b0;
    next_cnt  = cnt + 32'h0000_0001;
    if (cnt >= DIV - 1) begin
      next_cnt  = 32'h0000_0000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule // wnio_tick

// *** design/wnio_top.sv ***
// Digital I/O supervision of a battery wireless field transmitter.
// Assumes inputs synchronous to CLK_SYS except DI pins (synchronised here);
// the radio reports link success/failure per communication as pulses.
//
// Function
// - Disabled trigger mode ignores the input
// - Rising mode: send on low-to-high
// - Falling mode: send on high-to-low
// - Both mode: send on every change
// - Input state reported as 0 or 1
// - Triggers off at reset; global enable gates
// - Link lost after 1..10 failed periods
// - Outputs take startup value at power-on
// - Link loss drives configured output values
// - Power output raised 0..255 s early
// - Power rise coincides with wake-up
// - Warm-up beyond period keeps power on
// - Periodic sends independent of events
// - Temperature error reads 65535
// - Three analog types (off, current, voltage), default off
// - Off analog input reads 65535
// - Gateway slot index 1..55 accepted
// - Remote output follows gateway value
// - Link lost clears on recovery
`timescale 1ns/10ps
module wnio_top
  import wnio_pkg::*;
#(
  parameter int unsigned TICK_DIV = wnio_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                        CLK_SYS,
  input  wire logic                        RST_N,
  // Digital inputs and trigger setup
  input  wire logic [wnio_pkg::NUM_DI-1:0] DI_PIN,
  input  wire logic                        INPUT_EVENT_SEND_ENABLE,
  input  wire logic [2*wnio_pkg::NUM_DI-1:0] DI_TRIG_MODE,
  output logic      [wnio_pkg::NUM_DI-1:0] DI_STATE,
  // Communication schedule
  input  wire logic [wnio_pkg::PERIOD_W-1:0] COMM_PERIOD_S,
  input  wire logic [wnio_pkg::WARM_W-1:0] WARM_UP_S,
  input  wire logic                        COMM_DONE,
  input  wire logic                        COMM_OK,
  output logic                             COMM_REQ,
  output logic                             COMM_EVENT,
  output logic                             AWAKE,
  // Link-lost output
  input  wire logic [wnio_pkg::CYC_W-1:0]  LOST_CYCLES,
  input  wire logic [1:0]                  LOST_START_MODE,
  input  wire logic                        LOST_LOSS_ON,
  input  wire logic                        LOST_LAST_STATE,
  output logic                             LINK_LOST_OUT,
  // Remote switch output
  input  wire logic                        REMOTE_CMD,
  input  wire logic [1:0]                  REMOTE_START_MODE,
  input  wire logic [1:0]                  REMOTE_LOSS_MODE,
  input  wire logic                        REMOTE_LAST_STATE,
  output logic                             REMOTE_SWITCH_OUT,
  // External power output
  output logic                             EXT_POWER_OUT,
  // Slot index
  input  wire logic [wnio_pkg::SLOT_W-1:0] GATEWAY_SLOT_INDEX_IN,
  output logic      [wnio_pkg::SLOT_W-1:0] GATEWAY_SLOT_INDEX,
  output logic                             SLOT_INDEX_BAD,
  // Measurement readings
  input  wire logic                        TEMP_ERROR,
  input  wire logic [wnio_pkg::VAL_W-1:0]  TEMP_RAW,
  output logic      [wnio_pkg::VAL_W-1:0]  TEMP_VALUE,
  input  wire logic [2*wnio_pkg::NUM_AI-1:0] AI_TYPE,
  input  wire logic [wnio_pkg::NUM_AI*wnio_pkg::VAL_W-1:0] AI_RAW,
  output logic      [wnio_pkg::NUM_AI*wnio_pkg::VAL_W-1:0] AI_VALUE
);

  // ==========================================================================
  // Timebase
  logic tick;

  wnio_tick #(
    .DIV (TICK_DIV)
  ) u_tick (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .tick  (tick)
  );

  // ==========================================================================
  // Digital inputs
  logic [NUM_DI-1:0] di_meta;
  logic [NUM_DI-1:0] di_sync;
  logic [NUM_DI-1:0] di_prev;
  logic [NUM_DI-1:0] di_hit;
  logic              di_primed;

  genvar g;
  generate
    for (g = 0; g < NUM_DI; g++) begin : g_di
      wn_trig_t mode;
      logic     rise;
      logic     fall;
      assign mode = wn_trig_t'(DI_TRIG_MODE[2*g +: 2]);
      assign rise = di_sync[g] & ~di_prev[g];
      assign fall = ~di_sync[g] & di_prev[g];
      always_comb begin
        di_hit[g] = 1'b0;
        if (INPUT_EVENT_SEND_ENABLE && di_primed) begin
          case (mode)
            WN_TRIG_OFF:  di_hit[g] = 1'b0;
            WN_TRIG_RISE: di_hit[g] = rise;
            WN_TRIG_FALL: di_hit[g] = fall;
            WN_TRIG_BOTH: di_hit[g] = rise | fall;
            default:      di_hit[g] = 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // Primed masks events only until the first edge out of reset, while di_sync is still zero
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      di_meta   <= 4'h0;
      di_sync   <= 4'h0;
      di_prev   <= 4'h0;
      di_primed <= 1'b0;
    end else begin
      di_meta   <= DI_PIN;
      di_sync   <= di_meta;
      di_prev   <= di_sync;
      di_primed <= 1'b1;
    end
  end

  assign DI_STATE = di_prev;

  // ==========================================================================
  // Communication schedule
  wn_state_t               state;
  wn_state_t               next_state;
  logic [PERIOD_W-1:0]     sec_left;
  logic [PERIOD_W-1:0]     next_sec_left;
  logic                    ev_pend;
  logic                    next_ev_pend;
  logic                    req_event;
  logic                    next_req_event;
  logic                    warm_always;
  logic                    period_due;

  // Warm-up not shorter than the period means the sensors never sleep
  assign warm_always = ({8'h00, WARM_UP_S} >= COMM_PERIOD_S) && (WARM_UP_S != 8'h00);
  assign period_due  = tick && (sec_left <= 16'h0001);

  always_comb begin
    next_state     = state;
    next_sec_left  = sec_left;
    next_ev_pend   = ev_pend | (|di_hit);   // Event set wins over the clear below
    next_req_event = req_event;
    // A period falling due mid-send is kept for the next tick, not dropped
    if (tick && !(period_due && state == WN_ST_SEND)) begin
      next_sec_left = (sec_left <= 16'h0001) ? COMM_PERIOD_S : sec_left - 16'h0001;
    end
    case (state)
      WN_ST_SLEEP: begin
        if ({8'h00, WARM_UP_S} >= sec_left && WARM_UP_S != 8'h00) begin
          next_state = WN_ST_WARM;
        end
        if (period_due || ev_pend) begin
          next_state     = WN_ST_SEND;
          next_req_event = ev_pend & ~period_due;
          next_ev_pend   = |di_hit;
        end
      end
      WN_ST_WARM: begin
        if (period_due || ev_pend) begin
          next_state     = WN_ST_SEND;
          next_req_event = ev_pend & ~period_due;
          next_ev_pend   = |di_hit;
        end
      end
      WN_ST_SEND: begin
        if (COMM_DONE) begin
          next_state     = WN_ST_SLEEP;
          next_req_event = 1'b0;
        end
      end
      default: next_state = WN_ST_SLEEP;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state     <= WN_ST_SLEEP;
      sec_left  <= 16'h0000;
      ev_pend   <= 1'b0;
      req_event <= 1'b0;
    end else begin
      state     <= next_state;
      sec_left  <= next_sec_left;
      ev_pend   <= next_ev_pend;
      req_event <= next_req_event;
    end
  end

  assign COMM_REQ   = (state == WN_ST_SEND);
  assign COMM_EVENT = req_event;
  assign AWAKE      = (state != WN_ST_SLEEP);

  // ==========================================================================
  // Link supervision
  logic [CYC_W-1:0] miss_cnt;
  logic [CYC_W-1:0] next_miss_cnt;
  logic [CYC_W-1:0] cyc_lim;
  logic             lost;
  logic             next_lost;
  logic             started;

  // Out-of-range counts are clamped to the legal 1..10 window
  assign cyc_lim = (LOST_CYCLES < CYC_MIN) ? CYC_MIN :
                   (LOST_CYCLES > CYC_MAX) ? CYC_MAX : LOST_CYCLES;

  always_comb begin
    next_miss_cnt = miss_cnt;
    next_lost     = lost;
    if (COMM_DONE && COMM_OK) begin
      next_miss_cnt = 4'h0;
      next_lost     = 1'b0;
    end else if (COMM_DONE) begin
      if (miss_cnt < cyc_lim) begin
        next_miss_cnt = miss_cnt + 4'h1;
      end
      if (miss_cnt + 4'h1 >= cyc_lim) begin
        next_lost = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      miss_cnt <= 4'h0;
      lost     <= 1'b0;
    end else begin
      miss_cnt <= next_miss_cnt;
      lost     <= next_lost;
    end
  end

  // ==========================================================================
  // Output drivers
  logic lost_q;
  logic next_lost_q;
  logic rem_q;
  logic next_rem_q;

  // Startup value is loaded one edge after reset release, since a port
  // may not feed the asynchronous reset branch
  always_comb begin
    next_lost_q = lost_q;
    next_rem_q  = rem_q;
    if (!started) begin
      case (wn_start_t'(LOST_START_MODE))
        WN_START_ON:   next_lost_q = 1'b1;
        WN_START_LAST: next_lost_q = LOST_LAST_STATE;
        default:       next_lost_q = 1'b0;
      endcase
      case (wn_start_t'(REMOTE_START_MODE))
        WN_START_ON:   next_rem_q = 1'b1;
        WN_START_LAST: next_rem_q = REMOTE_LAST_STATE;
        default:       next_rem_q = 1'b0;
      endcase
    end else begin
      if (COMM_DONE && COMM_OK) begin
        next_lost_q = 1'b0;
      end else if (next_lost && !lost) begin
        next_lost_q = LOST_LOSS_ON;
      end
      if (lost) begin
        case (wn_loss_t'(REMOTE_LOSS_MODE))
          WN_LOSS_ON:  next_rem_q = 1'b1;
          WN_LOSS_OFF: next_rem_q = 1'b0;
          default:     next_rem_q = rem_q;
        endcase
      end else begin
        next_rem_q = REMOTE_CMD;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      started <= 1'b0;
      lost_q  <= 1'b0;
      rem_q   <= 1'b0;
      EXT_POWER_OUT <= 1'b0;
    end else begin
      started <= 1'b1;
      lost_q  <= next_lost_q;
      rem_q   <= next_rem_q;
      EXT_POWER_OUT <= warm_always || (next_state != WN_ST_SLEEP && WARM_UP_S != 8'h00);
    end
  end

  assign LINK_LOST_OUT     = lost_q;
  assign REMOTE_SWITCH_OUT = rem_q;

  // ==========================================================================
  // Slot index and readings
  logic                          slot_ok;
  logic [NUM_AI*VAL_W-1:0]       next_ai;

  assign slot_ok = (GATEWAY_SLOT_INDEX_IN >= SLOT_MIN) && (GATEWAY_SLOT_INDEX_IN <= SLOT_MAX);

  generate
    for (g = 0; g < NUM_AI; g++) begin : g_ai
      assign next_ai[g*VAL_W +: VAL_W] = (wn_ai_t'(AI_TYPE[2*g +: 2]) == WN_AI_OFF) ?
                                         SENTINEL : AI_RAW[g*VAL_W +: VAL_W];
    end
  endgenerate

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      GATEWAY_SLOT_INDEX <= 6'h01;
      SLOT_INDEX_BAD     <= 1'b0;
      TEMP_VALUE         <= 16'hFFFF;
      AI_VALUE           <= {NUM_AI{16'hFFFF}};
    end else begin
      if (slot_ok) begin
        GATEWAY_SLOT_INDEX <= GATEWAY_SLOT_INDEX_IN;
      end
      SLOT_INDEX_BAD <= ~slot_ok;
      TEMP_VALUE     <= TEMP_ERROR ? SENTINEL : TEMP_RAW;
      AI_VALUE       <= next_ai;
    end
  end

endmodule // wnio_top

// *** verif/wnio_props.sv ***
// Port checker for wnio_top: sentinels, slot index, input state, link, power.
// Assumes one clock domain; bound into every wnio_top instance.
`timescale 1ns/10ps
module wnio_props
  import wnio_pkg::*;
(
  // Clock and reset
  input wire logic                    CLK_SYS,
  input wire logic                    RST_N,
  // Watched ports
  input wire logic [NUM_DI-1:0]       DI_PIN,
  input wire logic [NUM_DI-1:0]       DI_STATE,
  input wire logic [PERIOD_W-1:0]     COMM_PERIOD_S,
  input wire logic [WARM_W-1:0]       WARM_UP_S,
  input wire logic                    COMM_DONE,
  input wire logic                    COMM_OK,
  input wire logic                    COMM_REQ,
  input wire logic                    COMM_EVENT,
  input wire logic                    AWAKE,
  input wire logic [CYC_W-1:0]        LOST_CYCLES,
  input wire logic [1:0]              LOST_START_MODE,
  input wire logic                    LOST_LOSS_ON,
  input wire logic                    LINK_LOST_OUT,
  input wire logic [1:0]              REMOTE_LOSS_MODE,
  input wire logic                    REMOTE_SWITCH_OUT,
  input wire logic                    EXT_POWER_OUT,
  input wire logic [SLOT_W-1:0]       GATEWAY_SLOT_INDEX_IN,
  input wire logic [SLOT_W-1:0]       GATEWAY_SLOT_INDEX,
  input wire logic                    SLOT_INDEX_BAD,
  input wire logic                    TEMP_ERROR,
  input wire logic [VAL_W-1:0]        TEMP_VALUE,
  input wire logic [2*NUM_AI-1:0]     AI_TYPE,
  input wire logic [NUM_AI*VAL_W-1:0] AI_VALUE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  // ==========================================================================
  // Assertions
  a_temp_sentinel: assert property (TEMP_ERROR |=> TEMP_VALUE == SENTINEL)
    else $error("temp reading not sentinel");
  a_ai_off: assert property (AI_TYPE[1:0] == WN_AI_OFF |=> AI_VALUE[15:0] == SENTINEL)
    else $error("analog reading not sentinel");
  a_slot_keep: assert property ((GATEWAY_SLOT_INDEX_IN == 6'h00 || GATEWAY_SLOT_INDEX_IN > SLOT_MAX)
    |=> SLOT_INDEX_BAD && $stable(GATEWAY_SLOT_INDEX)) else $error("bad slot index taken");
  a_di_follow: assert property ($stable(DI_PIN)[*5] |-> DI_STATE == DI_PIN)
    else $error("input state lags pin");
  a_lost_set: assert property (COMM_DONE && !COMM_OK && LOST_CYCLES == CYC_MIN
    |-> ##[2:3] LINK_LOST_OUT == LOST_LOSS_ON) else $error("link lost not raised");
  a_lost_clear: assert property (COMM_DONE && COMM_OK |-> ##[2:3] !LINK_LOST_OUT)
    else $error("link lost not cleared");
  a_power_full: assert property ((WARM_UP_S > COMM_PERIOD_S && COMM_PERIOD_S != 16'h0000)[*4]
    |-> EXT_POWER_OUT) else $error("power not held on");
  a_power_wake: assert property (EXT_POWER_OUT && WARM_UP_S < COMM_PERIOD_S |-> AWAKE)
    else $error("power on while asleep");
  a_remote_loss: assert property ($rose(LINK_LOST_OUT) && LOST_START_MODE == WN_START_OFF
    && REMOTE_LOSS_MODE == WN_LOSS_ON |=> REMOTE_SWITCH_OUT) else $error("remote loss value");

  cover property (COMM_REQ && COMM_EVENT);
  cover property ($rose(LINK_LOST_OUT));
  cover property ($rose(EXT_POWER_OUT));
endmodule // wnio_props

bind wnio_top wnio_props u_props (.*);

// *** verif/wnio_radio.sv ***
// Radio model: answers each request with a one-cycle done after dly cycles.
// Assumes req holds until done is sampled; dly above zero.
`timescale 1ns/10ps
module wnio_radio (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Request side
  input  wire logic       req,
  input  wire logic       ok_in,
  input  wire logic [7:0] dly,
  output logic            done,
  output logic            ok
);
  // ==========================================================================
  // Answer timing
  logic [7:0] cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt <= 8'h00;
    else if (!req || done) cnt <= 8'h00;
    else cnt <= cnt + 8'h01;
  end
  assign done = req && (cnt == dly);
  // Outside done the status means nothing, so show its inverse there
  assign ok = done ? ok_in : ~ok_in;
endmodule // wnio_radio

// *** verif/wireless_node_io_trigger_control_test.sv ***
// Self-checking bench for wnio_top with a radio partner model.
// Assumes TICK_DIV cut to 50 cycles per second; inputs change at falling edges.
`timescale 1ns/10ps
module wireless_node_io_trigger_control_test;
  import wnio_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, en = 1'b0, ok_in = 1'b1, ev_d = 1'b0;
  logic        done, ok, req, evt, awake, ll, rs, pw, bad;
  logic        lon = 1'b1, llast = 1'b0, rlast = 1'b0, cmd = 1'b0, terr = 1'b0;
  logic [3:0]  di = 4'h0, st, cyc = 4'h1;
  logic [7:0]  mode = 8'h00, warm = 8'h00, ait = 8'h00;
  logic [15:0] per = 16'h00FF, traw = 16'h0000, tv;
  logic [1:0]  lsm = WN_START_OFF, rsm = WN_START_OFF, rlm = WN_LOSS_ON;
  logic [5:0]  sin = 6'h01, slot;
  logic [63:0] araw = 64'h0004_0003_0002_0001, av;
  int          errors = 0, n_tests = 0, cyc_n = 0, n_ev = 0, t0, k;
  // Rows: trigger mode, enable, start level, event expected
  logic [4:0]  rows [9] = '{5'h04, 5'h06, 5'h0D, 5'h0E, 5'h14, 5'h17, 5'h1D, 5'h1F, 5'h08};

  always #50 clk = ~clk;

  wnio_top #(.TICK_DIV(50)) u_dut (
    .CLK_SYS(clk), .RST_N(rst_n), .DI_PIN(di), .INPUT_EVENT_SEND_ENABLE(en),
    .DI_TRIG_MODE(mode), .DI_STATE(st), .COMM_PERIOD_S(per), .WARM_UP_S(warm),
    .COMM_DONE(done), .COMM_OK(ok), .COMM_REQ(req), .COMM_EVENT(evt), .AWAKE(awake),
    .LOST_CYCLES(cyc), .LOST_START_MODE(lsm), .LOST_LOSS_ON(lon), .LOST_LAST_STATE(llast),
    .LINK_LOST_OUT(ll), .REMOTE_CMD(cmd), .REMOTE_START_MODE(rsm), .REMOTE_LOSS_MODE(rlm),
    .REMOTE_LAST_STATE(rlast), .REMOTE_SWITCH_OUT(rs), .EXT_POWER_OUT(pw),
    .GATEWAY_SLOT_INDEX_IN(sin), .GATEWAY_SLOT_INDEX(slot), .SLOT_INDEX_BAD(bad),
    .TEMP_ERROR(terr), .TEMP_RAW(traw), .TEMP_VALUE(tv), .AI_TYPE(ait), .AI_RAW(araw),
    .AI_VALUE(av));
  wnio_radio u_radio (.clk(clk), .rst_n(rst_n), .req(req), .ok_in(ok_in), .dly(8'h03),
    .done(done), .ok(ok));

  // ==========================================================================
  // Helpers
  // Counts event requests, one per rising request, so doubles show up
  always @(posedge clk) begin
    if (req && evt && !ev_d) n_ev++;
    ev_d <= req && evt;
  end
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 25000) begin
      errors++;
      test_done;
    end
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask

  // One event communication on input 0, which is set to trigger on both edges
  task automatic comm(input logic o);
    ok_in = o;
    di[0] = ~di[0];
    while (!(req && evt)) @(negedge clk);
    while (req) @(negedge clk);
    wt(4);
  endtask

  task test_done;
    $display("errors=%0d checks=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================================================
  // Sequence
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk({slot, tv, req}, {6'h01, SENTINEL, 1'b0}, "reset values");
    rst_n = 1'b1;
    wt(4);
    for (int r = 0; r < 9; r++) begin
      mode = 8'h00;
      di[r%4] = rows[r][1];
      wt(8);
      mode[2*(r%4)+:2] = rows[r][4:3];
      en = rows[r][2];
      wt(2);
      k = n_ev;
      di[r%4] = ~rows[r][1];
      wt(30);
      chk(n_ev - k, rows[r][0], "event trigger");
    end
    mode = 8'h00;
    di = 4'hA;
    wt(6);
    chk(st, 4'hA, "input state");
    mode = 8'h03;
    en = 1'b1;
    cyc = 4'h2;
    cmd = 1'b1;
    wt(4);
    chk(rs, 1'b1, "remote follow");
    cmd = 1'b0;
    comm(1'b0);
    chk(ll, 1'b0, "lost too early");
    comm(1'b0);
    chk({ll, rs}, 2'b11, "lost and remote loss");
    comm(1'b1);
    chk({ll, rs}, 2'b00, "recovery");
    cyc = 4'h1;
    cmd = 1'b1;
    rlm = WN_LOSS_HOLD;
    comm(1'b0);
    cmd = 1'b0;
    wt(2);
    chk({ll, rs}, 2'b11, "lost after one, remote held");
    comm(1'b1);
    chk(rs, 1'b0, "follow after recovery");
    terr = 1'b1;
    wt(2);
    chk(tv, SENTINEL, "temp error");
    terr = 1'b0;
    traw = 16'h1234;
    wt(2);
    chk(tv, 16'h1234, "temp value");
    chk(av, {4{SENTINEL}}, "analog off");
    ait = 8'h24;
    wt(2);
    chk(av, {SENTINEL, 16'h0003, 16'h0002, SENTINEL}, "analog types");
    sin = 6'h37;
    wt(2);
    chk({slot, bad}, 7'h6E, "slot max");
    sin = 6'h38;
    wt(2);
    chk({slot, bad}, 7'h6F, "slot above");
    sin = 6'h00;
    wt(2);
    chk({slot, bad}, 7'h6F, "slot zero");
    per = 16'h0014;
    warm = 8'h05;
    while (!pw) @(negedge clk);
    chk({awake, req}, 2'b10, "power at wake");
    t0 = cyc_n;
    while (!req) @(negedge clk);
    chk(cyc_n - t0 >= 240 && cyc_n - t0 <= 255, 1'b1, "warm-up lead");
    t0 = cyc_n;
    while (req) @(negedge clk);
    comm(1'b1);
    while (!(req && !evt)) @(negedge clk);
    chk(cyc_n - t0 >= 990 && cyc_n - t0 <= 1010, 1'b1, "period");
    warm = 8'h1E;
    wt(5);
    k = 0;
    repeat (1100) begin
      @(negedge clk);
      if (pw !== 1'b1) k++;
    end
    chk(k == 0, 1'b1, "power held");
    lsm = WN_START_ON;
    rsm = WN_START_LAST;
    rlast = 1'b1;
    rst_n = 1'b0;
    wt(3);
    rst_n = 1'b1;
    @(negedge clk);
    chk({ll, rs}, 2'b11, "startup values");
    wt(2);
    chk(rs, 1'b0, "follow after startup");
    test_done;
  end
endmodule // wireless_node_io_trigger_control_test
